// ---- verilog/fnd_params.svh ----
`ifndef FND_PARAMS_SVH
`define FND_PARAMS_SVH

// Register indices, byte address is four times the index
`define FND_IDX_REF 6'h02
`define FND_IDX_INT 6'h03
`define FND_IDX_FRAC 6'h04
`define FND_IDX_OSC 6'h05
`define FND_IDX_MODCFG 6'h06
`define FND_IDX_PRESC 6'h08
`define FND_IDX_EXACT 6'h0C
`define FND_IDX_STATUS 6'h10
`define FND_IDX_ACTDIV 6'h11

// Field widths and positions
`define FND_INT_W 19
`define FND_FRAC_W 24
`define FND_REF_W 14
`define FND_STEP_W 14
`define FND_DIV_W 20
`define FND_MODCFG_FRAC_EN 11
`define FND_MODCFG_BYPASS 7
`define FND_PRESC_BIT 19
`define FND_OSC_ADDR_LSB 0
`define FND_OSC_ADDR_MSB 2
`define FND_OSC_DATA_LSB 3
`define FND_OSC_DATA_MSB 11
`define FND_OSC_REG_DIFF 3'h1
`define FND_OSC_REG_DIV 3'h2
`define FND_OSC_DIFF_BIT 8

// Reset values
`define FND_REF_RST 14'h0001
`define FND_INT_RST 19'h0_0014
`define FND_FRAC_RST 24'h00_0000
`define FND_STEP_RST 14'h0000

// Legal integer ratios
`define FND_INT_MIN_INTMODE 19'h0_0010
`define FND_INT_MAX_INTMODE 19'h7_FFFF
`define FND_INT_MIN_FRACMODE 19'h0_0014
`define FND_INT_MAX_FRACMODE 19'h7_FFFC

`endif

// ---- verilog/fnd_pkg.sv ----
package fnd_pkg;

  typedef enum logic [1:0] {
    FND_MODE_INT = 2'b00,
    FND_MODE_FRAC = 2'b01,
    FND_MODE_EXACT = 2'b10
  } fnd_mode_t;

  typedef logic [18:0] fnd_int_t;
  typedef logic [23:0] fnd_frac_t;
  typedef logic [13:0] fnd_step_t;
  typedef logic [19:0] fnd_div_t;

endpackage

// ---- verilog/fnd_dsm.sv ----
`include "fnd_params.svh"

module fnd_dsm (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Comparison clock tick and atomic load
  input wire logic tick,
  input wire logic load,
  input wire fnd_pkg::fnd_mode_t mode,
  input wire fnd_pkg::fnd_int_t n_int,
  input wire fnd_pkg::fnd_frac_t frac,
  input wire fnd_pkg::fnd_step_t steps,
  // Divide ratio for this comparison cycle
  output fnd_pkg::fnd_div_t div_val,
  output logic div_strobe
);

  logic [23:0] acc;
  logic [13:0] cyc;
  logic [23:0] excess;
  logic corr_pending;
  logic [37:0] prod;
  logic [24:0] sum_raw;
  logic [24:0] sum_fix;
  logic corr_apply;
  logic cyc_wrap;
  logic mod_on;
  logic exact_on;

  // Excess of steps times the rounded-up fraction over a whole modulus
  assign prod = 38'(steps) * 38'(frac);
  assign mod_on = (mode != fnd_pkg::FND_MODE_INT);
  assign exact_on = (mode == fnd_pkg::FND_MODE_EXACT);
  assign sum_raw = {1'b0, acc} + {1'b0, frac};
  assign corr_apply = exact_on & corr_pending & (sum_raw >= {1'b0, excess});
  assign sum_fix = corr_apply ? (sum_raw - {1'b0, excess}) : sum_raw;
  assign cyc_wrap = exact_on & (cyc == (steps - 14'h0001));

  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= 24'h00_0000;
      cyc <= 14'h0000;
      excess <= 24'h00_0000;
      corr_pending <= 1'b0;
      div_val <= 20'h0_0000;
      div_strobe <= 1'b0;
    end else if (load) begin
      // New value restarts the accumulator, no mixed ratio
      acc <= 24'h00_0000;
      cyc <= 14'h0000;
      excess <= prod[23:0];
      corr_pending <= 1'b0;
      // Ratio in use stays until the next comparison boundary
      if (tick) begin
        div_val <= {1'b0, n_int};
      end
      div_strobe <= tick;
    end else if (tick) begin
      div_strobe <= 1'b1;
      if (mod_on) begin
        // Carry out of the 24-bit accumulator adds one count
        acc <= sum_fix[23:0];
        div_val <= {1'b0, n_int} + {19'h0_0000, sum_fix[24]};
        // Exact mode trims the excess once per step period
        cyc <= cyc_wrap ? 14'h0000 : cyc + 14'h0001;
        corr_pending <= cyc_wrap | (corr_pending & ~corr_apply);
      end else begin
        acc <= 24'h00_0000;
        div_val <= {1'b0, n_int};
      end
    end else begin
      div_strobe <= 1'b0;
    end
  end

endmodule

// ---- verilog/fnd_top.sv ----
// Added by the designer: the placing of the registers and the APB slave port.
`include "fnd_params.svh"

// Functional notes
// - Integer mode: modulator off, ratio 16..2^19-1
// - Prescaler bit selects divide-by-1 or 2
// - Oscillator registers written only via register five
// - Main output twice fundamental; divided by k
// - Output divide k is a power of two, 1..128
// - Fractional mode integer ratio 20..524284
// - Fraction equals register four over 2^24
// - Reference divided by R gives comparison rate
// - Integer 19 bits, fraction 24 bits
// - Fixed binary modulus of 2^24
// - Binary-exact ratios give zero error
// - Register twelve holds steps per integer boundary
// - Exact mode keeps full 24-bit modulus
module fnd_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Reference input pin
  input wire logic REF_IN,
  // Feedback divider
  output logic PD_TICK,
  output fnd_pkg::fnd_div_t FB_DIV,
  output logic FB_DIV_STROBE,
  output logic MOD_ENABLE,
  output logic MOD_BYPASS,
  output logic PRESCALE_DIV2,
  // Oscillator subsystem indirect write port
  output logic OSC_WR_STROBE,
  output logic [2:0] OSC_WR_ADDR,
  output logic [8:0] OSC_WR_DATA,
  output logic [7:0] OUT_DIV_K,
  output logic OUT_DIFF_EN
);

  // Output divide factor from the three-bit select
  function automatic logic [7:0] k_of(input logic [2:0] sel);
    k_of = 8'h01 << sel;
  endfunction

  // Range check of an integer ratio
  function automatic logic in_range(input fnd_pkg::fnd_int_t n, input fnd_pkg::fnd_int_t lo,
                                    input fnd_pkg::fnd_int_t hi);
    in_range = (n >= lo) && (n <= hi);
  endfunction

  // Reference synchroniser and edge detect
  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  logic ref_rise;
  logic [13:0] r_cnt;
  logic [13:0] r_last;

  // Software-visible registers
  logic [13:0] ref_div;
  fnd_pkg::fnd_int_t int_stage;
  fnd_pkg::fnd_frac_t frac_stage;
  fnd_pkg::fnd_step_t steps_stage;
  logic frac_en;
  logic bypass;
  logic presc;
  logic [11:0] osc_cmd;

  // Values in use by the divider
  fnd_pkg::fnd_int_t int_act;
  fnd_pkg::fnd_frac_t frac_act;
  fnd_pkg::fnd_step_t steps_act;
  fnd_pkg::fnd_mode_t mode_act;
  logic pending;
  logic load;
  logic load_now;
  logic [2:0] osc_div_sel;

  // APB decode
  logic apb_access;
  logic apb_done;
  logic apb_wr;
  logic [5:0] idx;
  logic aligned;
  logic hit_ref;
  logic hit_int;
  logic hit_frac;
  logic hit_osc;
  logic hit_modcfg;
  logic hit_presc;
  logic hit_exact;
  logic hit_status;
  logic hit_actdiv;
  logic mapped;
  logic ratio_write;
  logic next_pending;
  logic [31:0] rd_mux;

  // Staged mode and ratio checks
  fnd_pkg::fnd_mode_t mode_stage;
  logic mod_on_stage;
  logic int_ok;
  logic steps_ok;
  logic [31:0] status_word;
  logic [2:0] osc_addr_field;
  logic [8:0] osc_data_field;
  logic osc_write;
  logic osc_to_div;
  logic osc_to_diff;

  assign apb_access = PSEL & PENABLE;
  assign apb_done = apb_access & PREADY;
  assign apb_wr = apb_done & PWRITE;
  assign idx = PADDR[7:2];
  assign aligned = (PADDR[1:0] == 2'b00);
  assign hit_ref = aligned & (idx == `FND_IDX_REF);
  assign hit_int = aligned & (idx == `FND_IDX_INT);
  assign hit_frac = aligned & (idx == `FND_IDX_FRAC);
  assign hit_osc = aligned & (idx == `FND_IDX_OSC);
  assign hit_modcfg = aligned & (idx == `FND_IDX_MODCFG);
  assign hit_presc = aligned & (idx == `FND_IDX_PRESC);
  assign hit_exact = aligned & (idx == `FND_IDX_EXACT);
  assign hit_status = aligned & (idx == `FND_IDX_STATUS);
  assign hit_actdiv = aligned & (idx == `FND_IDX_ACTDIV);
  assign mapped = hit_ref | hit_int | hit_frac | hit_osc | hit_modcfg | hit_presc | hit_exact |
                  hit_status | hit_actdiv;

  // Any write that changes the feedback ratio
  assign ratio_write = apb_wr & (hit_int | hit_frac | hit_exact | hit_modcfg);
  // A new write wins over the clear at the boundary
  assign next_pending = ratio_write | (pending & ~PD_TICK);
  // Staged values move only on a tick with no write in flight
  assign load_now = PD_TICK & pending & ~ratio_write;

  // Modulator in circuit only when enabled and not bypassed
  assign mod_on_stage = frac_en & ~bypass;
  assign mode_stage = !mod_on_stage ? fnd_pkg::FND_MODE_INT :
                      (steps_stage != `FND_STEP_RST) ? fnd_pkg::FND_MODE_EXACT :
                      fnd_pkg::FND_MODE_FRAC;
  assign int_ok = mod_on_stage ?
                  in_range(int_stage, `FND_INT_MIN_FRACMODE, `FND_INT_MAX_FRACMODE) :
                  in_range(int_stage, `FND_INT_MIN_INTMODE, `FND_INT_MAX_INTMODE);
  assign steps_ok = (steps_stage != `FND_STEP_RST);

  // Zero R behaves as one
  assign r_last = (ref_div == 14'h0000) ? 14'h0000 : (ref_div - 14'h0001);
  assign ref_rise = ref_sync & ~ref_prev;

  assign osc_addr_field = PWDATA[`FND_OSC_ADDR_MSB:`FND_OSC_ADDR_LSB];
  assign osc_data_field = PWDATA[`FND_OSC_DATA_MSB:`FND_OSC_DATA_LSB];

  // Oscillator command decode
  assign osc_write = apb_wr & hit_osc;
  assign osc_to_div = osc_write & (osc_addr_field == `FND_OSC_REG_DIV);
  assign osc_to_diff = osc_write & (osc_addr_field == `FND_OSC_REG_DIFF);

  assign status_word = {19'h0_0000, k_of(osc_div_sel), steps_ok, mode_act, ~int_ok, pending};

  assign rd_mux = hit_ref ? {18'h0_0000, ref_div} :
                  hit_int ? {13'h0000, int_stage} :
                  hit_frac ? {8'h00, frac_stage} :
                  hit_osc ? {20'h0_0000, osc_cmd} :
                  hit_modcfg ? ({31'h0000_0000, frac_en} << `FND_MODCFG_FRAC_EN) |
                               ({31'h0000_0000, bypass} << `FND_MODCFG_BYPASS) :
                  hit_presc ? ({31'h0000_0000, presc} << `FND_PRESC_BIT) :
                  hit_exact ? {18'h0_0000, steps_stage} :
                  hit_status ? status_word :
                  hit_actdiv ? {12'h000, FB_DIV} :
                  32'h0000_0000;

  // Reference pin through two flip-flops before use
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= REF_IN;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // Reference divider produces the comparison tick
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r_cnt <= 14'h0000;
      PD_TICK <= 1'b0;
    end else if (ref_rise) begin
      PD_TICK <= (r_cnt >= r_last);
      r_cnt <= (r_cnt >= r_last) ? 14'h0000 : r_cnt + 14'h0001;
    end else begin
      PD_TICK <= 1'b0;
    end
  end

  // APB handshake, one wait cycle in every access
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_access & ~PREADY;
      if (apb_access & ~PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
        PSLVERR <= ~mapped;
      end else begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // Ratio and reference registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ref_div <= `FND_REF_RST;
      int_stage <= `FND_INT_RST;
      frac_stage <= `FND_FRAC_RST;
      steps_stage <= `FND_STEP_RST;
    end else if (apb_wr) begin
      if (hit_ref) begin
        ref_div <= PWDATA[`FND_REF_W-1:0];
      end
      if (hit_int) begin
        int_stage <= PWDATA[`FND_INT_W-1:0];
      end
      if (hit_frac) begin
        frac_stage <= PWDATA[`FND_FRAC_W-1:0];
      end
      if (hit_exact) begin
        steps_stage <= PWDATA[`FND_STEP_W-1:0];
      end
    end
  end

  // Control and oscillator command registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      frac_en <= 1'b0;
      bypass <= 1'b1;
      presc <= 1'b0;
      osc_cmd <= 12'h000;
    end else if (apb_wr) begin
      if (hit_modcfg) begin
        frac_en <= PWDATA[`FND_MODCFG_FRAC_EN];
        bypass <= PWDATA[`FND_MODCFG_BYPASS];
      end
      if (hit_presc) begin
        presc <= PWDATA[`FND_PRESC_BIT];
      end
      if (hit_osc) begin
        osc_cmd <= PWDATA[`FND_OSC_DATA_MSB:0];
      end
    end
  end

  // Staged ratio moves to the divider only on a comparison tick
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pending <= 1'b0;
      load <= 1'b0;
      int_act <= `FND_INT_RST;
      frac_act <= `FND_FRAC_RST;
      steps_act <= `FND_STEP_RST;
      mode_act <= fnd_pkg::FND_MODE_INT;
    end else begin
      pending <= next_pending;
      load <= 1'b0;
      if (load_now) begin
        int_act <= int_stage;
        frac_act <= mod_on_stage ? frac_stage : `FND_FRAC_RST;
        steps_act <= steps_stage;
        mode_act <= mode_stage;
        load <= 1'b1;
      end
    end
  end

  // Modulator pins follow the configuration register, prescaler pin the prescaler register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MOD_ENABLE <= 1'b0;
      MOD_BYPASS <= 1'b1;
      PRESCALE_DIV2 <= 1'b0;
    end else begin
      MOD_ENABLE <= frac_en;
      MOD_BYPASS <= bypass;
      PRESCALE_DIV2 <= presc;
    end
  end

  // Indirect oscillator-subsystem writes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      OSC_WR_STROBE <= 1'b0;
      OSC_WR_ADDR <= 3'h0;
      OSC_WR_DATA <= 9'h000;
      osc_div_sel <= 3'h0;
      OUT_DIV_K <= 8'h01;
      OUT_DIFF_EN <= 1'b0;
    end else begin
      OSC_WR_STROBE <= osc_write;
      if (osc_write) begin
        OSC_WR_ADDR <= osc_addr_field;
        OSC_WR_DATA <= osc_data_field;
      end
      if (osc_to_div) begin
        osc_div_sel <= osc_data_field[2:0];
        OUT_DIV_K <= k_of(osc_data_field[2:0]);
      end
      if (osc_to_diff) begin
        OUT_DIFF_EN <= osc_data_field[`FND_OSC_DIFF_BIT];
      end
    end
  end

  // Per-cycle feedback ratio; main output is twice the fundamental
  fnd_dsm fnd_dsm_i (
    .clk(CLK),
    .srst(SRST),
    .tick(PD_TICK),
    .load(load),
    .mode(mode_act),
    .n_int(int_act),
    .frac(frac_act),
    .steps(steps_act),
    .div_val(FB_DIV),
    .div_strobe(FB_DIV_STROBE)
  );

endmodule

// ---- testbench/fnd_host_model.sv ----
module fnd_host_model (
  // Clock
  input wire logic clk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reference oscillator
  output logic ref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ref_out = 1'b0;
  end
  // Reference toggles every third clock
  always @(posedge clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h2) begin
      ref_out <= ~ref_out;
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- testbench/fnd_top_monitor.sv ----
`include "fnd_params.svh"
module fnd_top_monitor (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Divider and oscillator
  input wire logic PD_TICK,
  input wire fnd_pkg::fnd_div_t FB_DIV,
  input wire logic FB_DIV_STROBE,
  input wire logic MOD_ENABLE,
  input wire logic MOD_BYPASS,
  input wire logic OSC_WR_STROBE,
  input wire logic [2:0] OSC_WR_ADDR,
  input wire logic [8:0] OSC_WR_DATA,
  input wire logic [7:0] OUT_DIV_K
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] adr_osc = {`FND_IDX_OSC, 2'b00};
  localparam logic [7:0] adr_cfg = {`FND_IDX_MODCFG, 2'b00};
  wire done = PSEL && PENABLE && PREADY && PWRITE;
  wire osc_wr = done && PADDR == adr_osc;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_wr(a); done && PADDR == a; endsequence
  property p_rdy; s_setup |=> !PREADY ##1 PREADY ##1 !PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_err; s_setup ##0 PADDR[1:0] != 2'b00 |-> ##2 (PSLVERR && PRDATA == 32'h0000_0000); endproperty
  a_err: assert property (p_err) else $error("unaligned accepted");
  property p_osc;
    s_wr(adr_osc) |=> OSC_WR_STROBE && OSC_WR_ADDR == $past(PWDATA[2:0]) && OSC_WR_DATA == $past(PWDATA[11:3]);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator write lost");
  property p_src; OSC_WR_STROBE |-> $past(osc_wr); endproperty
  a_src: assert property (p_src) else $error("stray oscillator write");
  property p_k; OSC_WR_STROBE && OSC_WR_ADDR == 3'h2 |-> ##[0:2] OUT_DIV_K == 8'h01 << OSC_WR_DATA[2:0]; endproperty
  a_k: assert property (p_k) else $error("output divide wrong");
  property p_cfg;
    s_wr(adr_cfg) |-> ##2 (MOD_ENABLE == $past(PWDATA[11], 2) && MOD_BYPASS == $past(PWDATA[7], 2));
  endproperty
  a_cfg: assert property (p_cfg) else $error("modulator config wrong");
  property p_tick; PD_TICK |=> FB_DIV_STROBE && !PD_TICK ##1 !PD_TICK [*2]; endproperty
  a_tick: assert property (p_tick) else $error("strobe not after tick");
  property p_hold; !FB_DIV_STROBE |-> $stable(FB_DIV); endproperty
  a_hold: assert property (p_hold) else $error("ratio changed between ticks");
endmodule
bind fnd_top fnd_top_monitor fnd_top_monitor_i (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .PSLVERR, .PD_TICK, .FB_DIV, .FB_DIV_STROBE, .MOD_ENABLE, .MOD_BYPASS, .OSC_WR_STROBE, .OSC_WR_ADDR,
  .OSC_WR_DATA, .OUT_DIV_K);

// ---- testbench/tb_fnd_top.sv ----
`include "fnd_params.svh"
module tb_fnd_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK;
  logic SRST;
  wire logic PSEL, PENABLE, PWRITE, REF_IN, PREADY, PSLVERR, PD_TICK, FB_DIV_STROBE, MOD_ENABLE, MOD_BYPASS;
  wire logic PRESCALE_DIV2, OSC_WR_STROBE, OUT_DIFF_EN;
  wire logic [7:0] PADDR, OUT_DIV_K;
  wire logic [31:0] PWDATA, PRDATA;
  wire logic [2:0] OSC_WR_ADDR;
  wire logic [8:0] OSC_WR_DATA;
  wire fnd_pkg::fnd_div_t FB_DIV;
  int bad_count;
  int checks;
  logic [31:0] q;
  logic e;
  logic [31:0] s;
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  fnd_top fnd_top_i (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .REF_IN,
    .PD_TICK, .FB_DIV, .FB_DIV_STROBE, .MOD_ENABLE, .MOD_BYPASS, .PRESCALE_DIV2, .OSC_WR_STROBE, .OSC_WR_ADDR,
    .OSC_WR_DATA, .OUT_DIV_K, .OUT_DIFF_EN);
  fnd_host_model fnd_host_model_i (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR), .ref_out(REF_IN));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    fnd_host_model_i.xfer(1'b1, {i, 2'b00}, d, q, e);
  endtask
  task automatic rd(input logic [5:0] i);
    fnd_host_model_i.xfer(1'b0, {i, 2'b00}, 32'h0000_0000, q, e);
  endtask
  // Sum of n ratios after the new setting has loaded
  task automatic sum(input int n);
    int c;
    int t;
    s = 32'h0000_0000;
    c = 0;
    t = 0;
    while (c < n + 3 && t < 2000) begin
      @(posedge CLK);
      t++;
      if (FB_DIV_STROBE === 1'b1) begin
        c++;
        if (c > 3) s = s + 32'(FB_DIV);
      end
    end
  endtask
  task automatic t_reset();
    chk(32'({MOD_ENABLE, MOD_BYPASS, OUT_DIV_K}), 32'h0000_0101);
    rd(`FND_IDX_INT);
    chk(q, 32'h0000_0014);
  endtask
  task automatic t_int();
    fnd_pkg::fnd_int_t v[2];
    v = '{`FND_INT_MIN_INTMODE, `FND_INT_MAX_INTMODE};
    wr(`FND_IDX_MODCFG, 32'h0000_0080);
    foreach (v[j]) begin
      wr(`FND_IDX_INT, 32'(v[j]));
      rd(`FND_IDX_STATUS);
      chk(32'(q[3:1]), 32'h0000_0000);
      sum(2);
      chk(s, 32'(v[j]) * 2);
    end
  endtask
  task automatic t_frac();
    logic [23:0] f[2];
    int x[2];
    f = '{24'h80_0000, 24'h40_0000};
    x = '{82, 162};
    wr(`FND_IDX_MODCFG, 32'h0000_0800);
    wr(`FND_IDX_INT, 32'h0000_0014);
    foreach (f[j]) begin
      wr(`FND_IDX_FRAC, 32'(f[j]));
      sum(4 * (j + 1));
      chk(s, 32'(x[j]));
    end
    wr(`FND_IDX_INT, 32'h0007_FFFD);
    rd(`FND_IDX_STATUS);
    chk(32'(q[3:1]), 32'h0000_0003);
  endtask
  task automatic t_exact();
    wr(`FND_IDX_INT, 32'h0000_0046);
    wr(`FND_IDX_FRAC, 32'h0019_999A);
    wr(`FND_IDX_EXACT, 32'h0000_000A);
    // Let a comparison tick apply the staged mode
    repeat (12) @(posedge CLK);
    rd(`FND_IDX_STATUS);
    chk(32'(q[4:1]), 32'h0000_000C);
    sum(20);
    chk(s, 32'h0000_057A);
    wr(`FND_IDX_EXACT, 32'h0000_0000);
  endtask
  task automatic t_osc();
    for (int j = 0; j < 8; j++) begin
      wr(`FND_IDX_OSC, 32'((j << 3) | 2));
      repeat (3) @(posedge CLK);
      chk(32'(OUT_DIV_K), 32'(1 << j));
    end
    wr(`FND_IDX_OSC, 32'h0000_0801);
    repeat (3) @(posedge CLK);
    chk(32'({OSC_WR_ADDR, OUT_DIFF_EN}), 32'h0000_0003);
  endtask
  task automatic t_misc();
    fnd_host_model_i.xfer(1'b0, 8'h04, 32'h0000_0000, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    fnd_host_model_i.xfer(1'b0, 8'h0E, 32'h0000_0000, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    for (int p = 1; p >= 0; p--) begin
      wr(`FND_IDX_PRESC, 32'(p) << 19);
      repeat (3) @(posedge CLK);
      chk(32'(PRESCALE_DIV2), 32'(p));
    end
  endtask
  task automatic t_ref();
    int r[2];
    int g;
    r = '{3, 0};
    foreach (r[j]) begin
      wr(`FND_IDX_REF, 32'(r[j]));
      repeat (3) begin
        g = 0;
        do begin
          @(posedge CLK);
          g++;
        end while (PD_TICK !== 1'b1 && g < 100);
      end
      chk(32'(g), 32'(6 * (r[j] == 0 ? 1 : r[j])));
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    SRST = 1'b1;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    t_reset();
    t_int();
    t_frac();
    t_exact();
    t_osc();
    t_misc();
    t_ref();
    wrap_up();
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule
